// >>> verif/cbe_bus_agents.sv
// Other agents on the shared bus: stall pieces, data strobes, held reads
`timescale 1ns/1ps
module cbe_bus_agents (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic own_stall,
    input wire logic own_write,
    input wire logic stall_go,
    input wire logic data_go,
    input cbe_pkg::cbe_txn_t req,
    output logic stall_wire,
    output logic data_wire,
    output cbe_pkg::cbe_txn_t issue
);
    import cbe_pkg::*;
    logic [1:0] cnt_ff;
    cbe_txn_t held_ff;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_ff <= 2'h0;
            held_ff <= '0;
        end else begin
            // A peer stall always lasts two bus cycles
            if (cnt_ff != 2'h0) begin
                cnt_ff <= cnt_ff - 2'h1;
            end else if (stall_go) begin
                cnt_ff <= 2'h2;
            end
            if (req.valid) begin
                held_ff <= req;
            end else if (!stall_wire) begin
                held_ff.valid <= 1'b0;
            end
        end
    end
    assign stall_wire = own_stall | (cnt_ff != 2'h0);
    assign data_wire = own_write | data_go;
    always_comb begin
        issue = held_ff;
        // A read waits while anyone holds the stall wire
        issue.valid = held_ff.valid & !stall_wire;
    end
endmodule : cbe_bus_agents

// >>> verif/cbe_event_counters_tb.sv
// Self-checking bench for the cache and bus event counters
`timescale 1ns/1ps
module cbe_event_counters_tb;
    import cbe_pkg::*;
    logic ref_clk;
    logic resetn;
    cbe_sel_t sel;
    cbe_core_t core;
    cbe_bus_t bus;
    cbe_out_t out;
    logic stall_go;
    logic data_go;
    logic own_write;
    logic stall_wire;
    logic data_wire;
    cbe_txn_t req;
    cbe_txn_t fill;
    cbe_txn_t issue;
    logic [3:0] snoop;
    logic [7:0] s_inc;
    logic [7:0] s_drv;
    logic [7:0] s_iss;
    logic [7:0] s_bad;
    int failures;
    int checks_done;
    int cycles;
    assign bus = '{issue, fill, stall_wire, data_wire, own_write, snoop};
    cbe_event_counters uut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sel(sel),
        .core(core),
        .bus(bus),
        .out(out)
    );
    cbe_bus_agents agents (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .own_stall(out.bus_stall_drive),
        .own_write(own_write),
        .stall_go(stall_go),
        .data_go(data_go),
        .req(req),
        .stall_wire(stall_wire),
        .data_wire(data_wire),
        .issue(issue)
    );
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task give_verdict;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            give_verdict;
        end
    end
    task step;
        @(posedge ref_clk);
    endtask : step
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task put(input logic [7:0] e, input logic [7:0] u, input logic c, input logic a);
        sel <= '{e, u, c, a};
    endtask : put
    task clr;
        {s_inc, s_drv, s_iss, s_bad} = '0;
    endtask : clr
    // Sums over a window so the checks do not hang on exact latency
    task run(input int n);
        repeat (n) begin
            step;
            s_inc += out.increment;
            s_drv += out.bus_stall_drive;
            s_iss += issue.valid;
            s_bad += (issue.valid & stall_wire) | (out.issue_block ^ stall_wire);
        end
    endtask : run
    task ev(input logic [7:0] e, input logic [7:0] u, input cbe_core_t c, input logic [7:0] exp);
        put(e, u, 1'b0, 1'b0);
        core <= c;
        step;
        core <= '0;
        step;
        chk(out.increment, exp);
    endtask : ev
    task automatic t_dec;
        logic [7:0] en [9] = '{8'h4B, 8'h4B, 8'h4C, 8'h4E, 8'h60, 8'h61, 8'h62, 8'h4B, 8'h4D};
        logic [7:0] um [9] = '{8'h01, 8'h02, 8'h00, 8'h10, 8'h5A, 8'h5A, 8'h5A, 8'h03, 8'h00};
        for (int i = 0; i < 9; i++) begin
            put(en[i], um[i], 1'b1, 1'b1);
            step;
            step;
            chk(out.event_onehot, (i < 7) ? (8'h01 << i) : 8'h00);
        end
    endtask : t_dec
    task t_pf;
        cbe_core_t k;
        k = '0;
        k.pf_all_miss = 1'b1;
        ev(EVT_PF_MISS, UM_PF_ALL, k, 8'h01);
        ev(EVT_PF_MISS, UM_PF_OUTER, k, 8'h00);
        k = '0;
        k.pf_second_miss = 1'b1;
        k.pf_third_miss = 1'b1;
        ev(EVT_PF_MISS, UM_PF_OUTER, k, 8'h02);
        ev(EVT_PF_MISS, UM_PF_ALL, k, 8'h00);
        ev(EVT_PF_MISS, 8'h03, k, 8'h00);
    endtask : t_pf
    task t_load;
        cbe_core_t k;
        k = '0;
        k.swpf_start = 1'b1;
        k.swpf_line = 26'h0ABCDE;
        ev(EVT_LOAD_HIT_PF, UM_NONE, k, 8'h00);
        k = '0;
        k.load_issue = 1'b1;
        k.load_line = 26'h0ABCDE;
        ev(EVT_LOAD_HIT_PF, UM_NONE, k, 8'h01);
        k.load_line = 26'h0ABCDF;
        ev(EVT_LOAD_HIT_PF, UM_NONE, k, 8'h00);
        k = '0;
        k.swpf_done = 1'b1;
        ev(EVT_LOAD_HIT_PF, UM_NONE, k, 8'h00);
        k = '0;
        k.load_issue = 1'b1;
        k.load_line = 26'h0ABCDE;
        ev(EVT_LOAD_HIT_PF, UM_NONE, k, 8'h00);
        k = '0;
        k.swpf_start = 1'b1;
        k.swpf_done = 1'b1;
        k.swpf_line = 26'h0ABCDE;
        core <= k;
        step;
        k = '0;
        k.load_issue = 1'b1;
        k.load_line = 26'h0ABCDE;
        ev(EVT_LOAD_HIT_PF, UM_NONE, k, 8'h01);
    endtask : t_load
    task t_l1pf;
        cbe_core_t k;
        k = '0;
        k.l1_pf_req = 1'b1;
        k.l2_busy = 1'b1;
        k.retry_en = 1'b1;
        ev(EVT_L1_PF_REQ, UM_L1_PF, k, 8'h01);
        step;
        chk(out.pf_resubmit, 8'h01);
        step;
        chk(out.pf_resubmit, 8'h00);
        chk(out.increment, 8'h00);
        k.retry_en = 1'b0;
        ev(EVT_L1_PF_REQ, UM_L1_PF, k, 8'h01);
        step;
        chk(out.pf_resubmit, 8'h00);
    endtask : t_l1pf
    task automatic t_pend;
        cbe_kind_t kd [8] = '{TK_READ_LINE, TK_READ_LINE, TK_READ_LINE, TK_READ_LINE, TK_READ_LINE,
            TK_RFO, TK_IFETCH, TK_READ_LINE};
        cbe_src_t sr [8] = '{SRC_L1D, SRC_L2PF, SRC_L2PF, SRC_L1D, SRC_L1D, SRC_L1D, SRC_L1D, SRC_OTHER};
        logic [7:0] ao = 8'b11111001;
        logic [7:0] co = 8'b11100111;
        logic [7:0] ca = 8'b11110100;
        logic [7:0] aa = 8'b11111010;
        logic [7:0] ex = 8'b00010011;
        cbe_txn_t t;
        for (int i = 0; i < 8; i++) begin
            t = '{1'b1, kd[i], sr[i], co[i], ao[i]};
            put(EVT_READ_PEND, UM_NONE, ca[i], aa[i]);
            req <= t;
            step;
            req <= '0;
            step;
            step;
            chk(out.increment, {7'h0, ex[i]});
            fill <= t;
            step;
            fill <= '0;
            chk(out.increment, {7'h0, ex[i]});
            step;
            chk(out.increment, {7'h0, ex[i]});
            step;
            chk(out.increment, 8'h00);
        end
    endtask : t_pend
    task t_stall;
        for (int v = 11; v < 13; v++) begin
            clr;
            put(EVT_BUS_STALL, UM_NONE, 1'b0, 1'b0);
            snoop <= v[3:0];
            req <= '{1'b1, TK_RFO, SRC_L1D, 1'b1, 1'b1};
            step;
            snoop <= 4'h0;
            req <= '0;
            run(6);
            chk(s_drv, (v == 12) ? 8'h02 : 8'h00);
            chk(s_inc, (v == 12) ? 8'h01 : 8'h00);
            chk(s_iss, 8'h01);
            chk(s_bad, 8'h00);
        end
        clr;
        put(EVT_BUS_STALL, UM_NONE, 1'b0, 1'b1);
        stall_go <= 1'b1;
        step;
        stall_go <= 1'b0;
        run(6);
        chk(s_inc, 8'h01);
        chk(s_drv, 8'h00);
    endtask : t_stall
    task t_data;
        for (int a = 0; a < 2; a++) begin
            clr;
            put(EVT_DATA_VALID, 8'h5A, 1'b1, a[0]);
            own_write <= 1'b1;
            run(3);
            own_write <= 1'b0;
            data_go <= 1'b1;
            run(2);
            data_go <= 1'b0;
            run(3);
            if (a == 0) begin
                chk(s_inc, 8'h03);
            end else begin
                chk(s_inc, 8'h05);
            end
        end
    endtask : t_data
    initial begin
        resetn = 1'b0;
        sel = '0;
        core = '0;
        {stall_go, data_go, own_write} = 3'h0;
        {req, fill} = '0;
        snoop = 4'h0;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        repeat (6) step;
        resetn <= 1'b1;
        step;
        t_dec;
        t_pf;
        t_load;
        t_l1pf;
        t_pend;
        t_stall;
        t_data;
        give_verdict;
    end
endmodule : cbe_event_counters_tb

// >>> verilog/cbe_event_counters.sv
// Event selection and per-cycle increment for cache prefetch and bus events
// Behaviour
// - 4B/01 counts all-level prefetch misses
// - 4B/02 counts outer-level prefetch misses
// - 4C/00 counts loads hitting pending prefetch
// - 4E/10 counts every first-level prefetch request
// - Rejected requests are resubmitted or dropped
// - 60 adds pending line reads each cycle
// - 60 tracks only cacheable line reads
// - 60 core/agent qualified; 61, 62 agent only
// - 61 counts stall assertions, two cycles each
// - Near bus limit assert stall; block issue
// - 62 own agent counts own write data
// - 62 any agent counts every data cycle
`timescale 1ns/1ps
module cbe_event_counters (
    input wire logic ref_clk,
    input wire logic resetn,
    input cbe_pkg::cbe_sel_t sel,
    input cbe_pkg::cbe_core_t core,
    input cbe_pkg::cbe_bus_t bus,
    output cbe_pkg::cbe_out_t out
);
    import cbe_pkg::*;

    cbe_state_t s_ff;
    cbe_state_t nxt_s;
    logic [EV_N-1:0] ev;
    logic iss_ok;
    logic fil_ok;
    logic [1:0] iss_cls;
    logic [1:0] fil_cls;
    logic iss_sel;
    logic [INC_W-1:0] pend_sum;
    logic [INC_W-1:0] own_load;
    logic load_hit;
    logic wire_start;

    function automatic logic [EV_N-1:0] decode(input cbe_sel_t q);
        logic [EV_N-1:0] d;
        d = '0;
        case (q.event_num)
            EVT_PF_MISS: begin
                if (q.umask == UM_PF_ALL) begin
                    d[EV_PF_ALL] = 1'b1;
                end else if (q.umask == UM_PF_OUTER) begin
                    d[EV_PF_OUTER] = 1'b1;
                end
            end
            EVT_LOAD_HIT_PF: d[EV_LOAD_HIT] = (q.umask == UM_NONE);
            EVT_L1_PF_REQ: d[EV_L1_PF] = (q.umask == UM_L1_PF);
            // Qualifiers ride beside the mask, so any mask is taken here
            EVT_READ_PEND: d[EV_READ_PEND] = 1'b1;
            EVT_BUS_STALL: d[EV_STALL] = 1'b1;
            EVT_DATA_VALID: d[EV_DATA] = 1'b1;
            default: d = '0;
        endcase
        return d;
    endfunction : decode

    function automatic logic counted(input cbe_txn_t t);
        return t.valid && t.kind == TK_READ_LINE &&
            (t.src == SRC_L1D || t.src == SRC_L2PF);
    endfunction : counted

    function automatic logic [1:0] cls_of(input cbe_txn_t t);
        return !t.agent_own ? CLS_OAGENT : (t.core_own ? CLS_OWN : CLS_OCORE);
    endfunction : cls_of

    assign ev = decode(sel);
    assign iss_ok = counted(bus.issue);
    assign fil_ok = counted(bus.fill);
    assign iss_cls = cls_of(bus.issue);
    assign fil_cls = cls_of(bus.fill);
    // Core choice filters only this agent's reads; other agents have no core
    assign iss_sel = iss_ok && (iss_cls == CLS_OWN ||
        (iss_cls == CLS_OCORE && sel.core_all) ||
        (iss_cls == CLS_OAGENT && sel.agent_any));
    // A read counts from its issue cycle through its fill cycle
    assign pend_sum = INC_W'(s_ff.pend[CLS_OWN]) +
        (sel.core_all ? INC_W'(s_ff.pend[CLS_OCORE]) : '0) +
        (sel.agent_any ? INC_W'(s_ff.pend[CLS_OAGENT]) : '0) +
        INC_W'(iss_sel);
    assign own_load = INC_W'(s_ff.pend[CLS_OWN]) +
        INC_W'(s_ff.pend[CLS_OCORE]) + INC_W'(bus.snoop_pending);
    assign load_hit = core.load_issue && s_ff.swpf_busy &&
        core.load_line == s_ff.swpf_line;
    // Back-to-back stalls from other agents split into two-cycle pieces
    assign wire_start = bus.bus_not_ready_signal && !s_ff.wire_phase;

    always_comb begin
        nxt_s = s_ff;
        // A new prefetch start wins over completion of the old one
        if (core.swpf_start) begin
            nxt_s.swpf_busy = 1'b1;
            nxt_s.swpf_line = core.swpf_line;
        end else if (core.swpf_done) begin
            nxt_s.swpf_busy = 1'b0;
        end
        for (int i = 0; i < PEND_CLS; i++) begin
            if (iss_ok && iss_cls == 2'(i) && !(fil_ok && fil_cls == 2'(i))) begin
                if (s_ff.pend[i] != PEND_MAX) begin
                    nxt_s.pend[i] = s_ff.pend[i] + PEND_ONE;
                end
            end else if (fil_ok && fil_cls == 2'(i) && !(iss_ok && iss_cls == 2'(i))) begin
                if (s_ff.pend[i] != '0) begin
                    nxt_s.pend[i] = s_ff.pend[i] - PEND_ONE;
                end
            end
        end
        case (s_ff.stall)
            STALL_IDLE: begin
                if (own_load >= STALL_THRESH) begin
                    nxt_s.stall = STALL_FIRST;
                end
            end
            STALL_FIRST: nxt_s.stall = STALL_SECOND;
            STALL_SECOND: nxt_s.stall = STALL_IDLE;
            default: nxt_s.stall = STALL_IDLE;
        endcase
        nxt_s.wire_phase = bus.bus_not_ready_signal && !s_ff.wire_phase;
        // Only one retry slot: a fresh rejection while one waits drops the old
        nxt_s.resubmit = 1'b0;
        if (core.l1_pf_req) begin
            nxt_s.retry = core.l2_busy && core.retry_en;
        end else if (s_ff.retry && !core.l2_busy) begin
            nxt_s.retry = 1'b0;
            nxt_s.resubmit = 1'b1;
        end
        nxt_s.inc = '0;
        if (ev[EV_PF_ALL]) begin
            nxt_s.inc = INC_W'(core.pf_all_miss);
        end else if (ev[EV_PF_OUTER]) begin
            nxt_s.inc = INC_W'(core.pf_second_miss) +
                INC_W'(core.pf_third_miss);
        end else if (ev[EV_LOAD_HIT]) begin
            nxt_s.inc = INC_W'(load_hit);
        end else if (ev[EV_L1_PF]) begin
            // Rejected requests still count; resubmits are not new requests
            nxt_s.inc = INC_W'(core.l1_pf_req);
        end else if (ev[EV_READ_PEND]) begin
            nxt_s.inc = pend_sum;
        end else if (ev[EV_STALL]) begin
            nxt_s.inc = sel.agent_any ? INC_W'(wire_start) :
                INC_W'(s_ff.stall == STALL_FIRST);
        end else if (ev[EV_DATA]) begin
            nxt_s.inc = sel.agent_any ? INC_W'(bus.data_valid_strobe) :
                INC_W'(bus.own_data_valid);
        end
        nxt_s.onehot = ev;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Our own issue waits while any agent, us included, holds the stall
    assign out = '{
        increment: s_ff.inc,
        event_onehot: s_ff.onehot,
        bus_stall_drive: s_ff.stall != STALL_IDLE,
        issue_block: bus.bus_not_ready_signal || s_ff.stall != STALL_IDLE,
        pf_resubmit: s_ff.resubmit
    };

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    logic [INC_W-1:0] pend_all;
    assign pend_all = INC_W'(s_ff.pend[CLS_OWN]) +
        INC_W'(s_ff.pend[CLS_OCORE]) + INC_W'(s_ff.pend[CLS_OAGENT]);

    property p_pf_all;
        ev[EV_PF_ALL] && core.pf_all_miss |=> out.increment == 6'h01;
    endproperty
    a_pf_all: assert property (p_pf_all) else $error("all-level miss not counted");

    property p_pf_outer;
        ev[EV_PF_OUTER] && core.pf_second_miss && core.pf_third_miss
            |=> out.increment == 6'h02;
    endproperty
    a_pf_outer: assert property (p_pf_outer) else $error("outer miss pair not counted");

    property p_load_hit;
        ev[EV_LOAD_HIT] && core.swpf_start && !core.load_issue ##1
            ev[EV_LOAD_HIT] && core.load_issue && core.load_line == $past(core.swpf_line)
            |=> out.increment == 6'h01;
    endproperty
    a_load_hit: assert property (p_load_hit) else $error("load on pending prefetch missed");

    property p_l1_pf;
        ev[EV_L1_PF] && core.l1_pf_req && core.l2_busy
            |=> out.increment == 6'h01 && out.event_onehot[EV_L1_PF];
    endproperty
    a_l1_pf: assert property (p_l1_pf) else $error("rejected request not counted");

    property p_resubmit;
        core.l1_pf_req && core.l2_busy && core.retry_en ##1
            (!core.l1_pf_req && !core.l2_busy) |=> out.pf_resubmit ##1 !out.pf_resubmit;
    endproperty
    a_resubmit: assert property (p_resubmit) else $error("rejected request not resubmitted");

    property p_drop;
        core.l1_pf_req && core.l2_busy && !core.retry_en |=> !out.pf_resubmit [*2];
    endproperty
    a_drop: assert property (p_drop) else $error("dropped request came back");

    property p_pend_first;
        ev[EV_READ_PEND] && sel.core_all && sel.agent_any && pend_all == '0 &&
            bus.issue.valid && bus.issue.kind == TK_READ_LINE &&
            bus.issue.src == SRC_L1D |=> out.increment == 6'h01;
    endproperty
    a_pend_first: assert property (p_pend_first) else $error("issue cycle not pending");

    property p_rfo_ignored;
        pend_all == '0 && !(bus.issue.valid && bus.issue.kind == TK_READ_LINE)
            |=> pend_all == '0;
    endproperty
    a_rfo_ignored: assert property (p_rfo_ignored) else $error("non-line read tracked");

    property p_other_agent_hidden;
        ev[EV_READ_PEND] && !sel.agent_any && !sel.core_all &&
            s_ff.pend[CLS_OWN] == '0 && !iss_ok |=> out.increment == '0;
    endproperty
    a_other_agent_hidden: assert property (p_other_agent_hidden) else $error("qualifier leak");

    property p_stall_span;
        $rose(out.bus_stall_drive) |-> out.bus_stall_drive [*2] ##1 !out.bus_stall_drive;
    endproperty
    a_stall_span: assert property (p_stall_span) else $error("stall not two cycles");

    property p_stall_count;
        ev[EV_STALL] && !sel.agent_any && $rose(out.bus_stall_drive)
            |=> out.increment == 6'h01 ##1 out.increment == '0;
    endproperty
    a_stall_count: assert property (p_stall_count) else $error("stall counted wrongly");

    property p_stall_raise;
        !out.bus_stall_drive && own_load >= STALL_THRESH |=> out.bus_stall_drive;
    endproperty
    a_stall_raise: assert property (p_stall_raise) else $error("stall not raised near limit");

    property p_issue_block;
        bus.bus_not_ready_signal || out.bus_stall_drive |-> out.issue_block;
    endproperty
    a_issue_block: assert property (p_issue_block) else $error("issue not blocked");

    property p_own_data;
        ev[EV_DATA] && !sel.agent_any |=> out.increment == INC_W'($past(bus.own_data_valid));
    endproperty
    a_own_data: assert property (p_own_data) else $error("own data cycle miscounted");

    property p_any_data;
        ev[EV_DATA] && sel.agent_any |=> out.increment == INC_W'($past(bus.data_valid_strobe));
    endproperty
    a_any_data: assert property (p_any_data) else $error("data cycle miscounted");

    property p_unknown;
        ev == '0 |=> out.increment == '0 && out.event_onehot == '0;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown pair counted");

    property p_onehot;
        $onehot0(out.event_onehot);
    endproperty
    a_onehot: assert property (p_onehot) else $error("event choice not one-hot");

    property p_pend_all;
        ev[EV_READ_PEND] && sel.core_all && sel.agent_any && !iss_ok
            |=> out.increment == $past(pend_all);
    endproperty
    a_pend_all: assert property (p_pend_all) else $error("pending reads not summed");

    property p_resubmit_quiet;
        ev[EV_L1_PF] && !core.l1_pf_req |=> out.increment == '0;
    endproperty
    a_resubmit_quiet: assert property (p_resubmit_quiet) else $error("resubmit counted as request");

    property p_any_stall;
        ev[EV_STALL] && sel.agent_any && $rose(bus.bus_not_ready_signal)
            |=> out.increment == 6'h01;
    endproperty
    a_any_stall: assert property (p_any_stall) else $error("wire assertion not counted");

    // Start and done together leave the line pending, so a later load still hits
    property p_swpf_set_wins;
        core.swpf_start && core.swpf_done
            |=> s_ff.swpf_busy && s_ff.swpf_line == $past(core.swpf_line);
    endproperty
    a_swpf_set_wins: assert property (p_swpf_set_wins) else $error("prefetch done beat start");

    property p_latency;
        1'b1 |=> out.event_onehot == $past(ev);
    endproperty
    a_latency: assert property (p_latency) else $error("event choice late");

    c_pend_two: cover property (ev[EV_READ_PEND] ##1 out.increment == 6'h02);
    c_set_wins: cover property (core.swpf_start && core.swpf_done);
    c_stall: cover property ($rose(out.bus_stall_drive));
    c_resubmit: cover property (out.pf_resubmit);
    c_load_hit: cover property (ev[EV_LOAD_HIT] && load_hit);
endmodule : cbe_event_counters

// >>> verilog/cbe_pkg.sv
// Constants and carrier types for the cache and bus event counters
package cbe_pkg;
    localparam logic [7:0] EVT_PF_MISS = 8'h4B;
    localparam logic [7:0] UM_PF_ALL = 8'h01;
    localparam logic [7:0] UM_PF_OUTER = 8'h02;
    localparam logic [7:0] EVT_LOAD_HIT_PF = 8'h4C;
    localparam logic [7:0] UM_NONE = 8'h00;
    localparam logic [7:0] EVT_L1_PF_REQ = 8'h4E;
    localparam logic [7:0] UM_L1_PF = 8'h10;
    localparam logic [7:0] EVT_READ_PEND = 8'h60;
    localparam logic [7:0] EVT_BUS_STALL = 8'h61;
    localparam logic [7:0] EVT_DATA_VALID = 8'h62;
    // One-hot positions of the event choice
    localparam int EV_PF_ALL = 0;
    localparam int EV_PF_OUTER = 1;
    localparam int EV_LOAD_HIT = 2;
    localparam int EV_L1_PF = 3;
    localparam int EV_READ_PEND = 4;
    localparam int EV_STALL = 5;
    localparam int EV_DATA = 6;
    localparam int EV_N = 7;
    localparam int LINE_W = 26;
    localparam int PEND_W = 4;
    localparam int INC_W = 6;
    localparam int PEND_CLS = 3;
    localparam logic [1:0] CLS_OWN = 2'h0;
    localparam logic [1:0] CLS_OCORE = 2'h1;
    localparam logic [1:0] CLS_OAGENT = 2'h2;
    localparam logic [PEND_W-1:0] PEND_ONE = 4'h1;
    localparam logic [PEND_W-1:0] PEND_MAX = 4'hF;
    // Own outstanding data plus snoop work that counts as near the bus limit
    localparam logic [INC_W-1:0] STALL_THRESH = 6'h0C;

    typedef enum logic [2:0] {
        TK_READ_LINE = 3'h0,
        TK_RFO = 3'h1,
        TK_IFETCH = 3'h2,
        TK_WRITEBACK = 3'h3,
        TK_PARTIAL = 3'h4,
        TK_OTHER = 3'h5
    } cbe_kind_t;

    typedef enum logic [1:0] {
        SRC_L1D = 2'h0,
        SRC_L2PF = 2'h1,
        SRC_OTHER = 2'h2
    } cbe_src_t;

    typedef enum logic [1:0] {
        STALL_IDLE = 2'h0,
        STALL_FIRST = 2'h1,
        STALL_SECOND = 2'h2
    } cbe_stall_t;

    typedef struct packed {
        logic [7:0] event_num;
        logic [7:0] umask;
        logic core_all;
        logic agent_any;
    } cbe_sel_t;

    typedef struct packed {
        logic pf_all_miss;
        logic pf_second_miss;
        logic pf_third_miss;
        logic swpf_start;
        logic swpf_done;
        logic [LINE_W-1:0] swpf_line;
        logic load_issue;
        logic [LINE_W-1:0] load_line;
        logic l1_pf_req;
        logic l2_busy;
        logic retry_en;
    } cbe_core_t;

    typedef struct packed {
        logic valid;
        cbe_kind_t kind;
        cbe_src_t src;
        logic core_own;
        logic agent_own;
    } cbe_txn_t;

    typedef struct packed {
        cbe_txn_t issue;
        cbe_txn_t fill;
        logic bus_not_ready_signal;
        logic data_valid_strobe;
        logic own_data_valid;
        logic [PEND_W-1:0] snoop_pending;
    } cbe_bus_t;

    typedef struct packed {
        logic [INC_W-1:0] increment;
        logic [EV_N-1:0] event_onehot;
        logic bus_stall_drive;
        logic issue_block;
        logic pf_resubmit;
    } cbe_out_t;

    typedef struct packed {
        logic swpf_busy;
        logic [LINE_W-1:0] swpf_line;
        logic [PEND_CLS-1:0][PEND_W-1:0] pend;
        cbe_stall_t stall;
        logic wire_phase;
        logic retry;
        logic resubmit;
        logic [INC_W-1:0] inc;
        logic [EV_N-1:0] onehot;
    } cbe_state_t;
endpackage : cbe_pkg
